// ===== rtl/ppsf_pkg.sv
// Package for the port power status flag bank.
// Assumes a 32-bit APB slave on a single 25 MHz clock.
package ppsf_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] PPSF_ADDR_P2_INT_STAT = 8'h04;
    localparam logic [7:0] PPSF_ADDR_P1_GEN_STAT = 8'h08;
    localparam logic [7:0] PPSF_ADDR_CONTROL     = 8'h10;
    localparam logic [7:0] PPSF_ADDR_ERROR       = 8'h14;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PPSF_BIT_OVC        = 0;  // Port 2 interrupt status
    localparam int PPSF_BIT_RATION     = 7;  // Port 1 general status
    localparam int PPSF_BIT_CC         = 4;
    localparam int PPSF_BIT_PWR        = 3;
    localparam int PPSF_BIT_RESTART    = 0;  // Control
    localparam int PPSF_BIT_RATION_EN  = 1;
    localparam int PPSF_BIT_OVERRIDE   = 2;
    localparam int PPSF_BIT_ERR        = 0;  // Error register

    localparam logic [31:0] PPSF_ZERO_WORD = 32'h0000_0000;

    // Software control bits
    typedef struct packed {
        logic ration_enable;
        logic power_override;
    } ppsf_ctrl_type;

    localparam ppsf_ctrl_type PPSF_CTRL_RESET = '{1'b0, 1'b0};

endpackage

// ===== rtl/ppsf_status_flags.sv
// Port power status flags: port 2 overcurrent flag, port 2 error flag
// and alert, and the port 1 general status register, behind APB.
// Assumes comparator and rationing inputs come from pclk logic; the
// power enable pin is asynchronous and is synchronised here.
//
// Contract
// R1 - The overcurrent flag sets when bus current exceeds both the limit and the minimum threshold.
// R2 - A read clears the overcurrent flag only once the condition is gone, and clearing the error flag clears it too.
// R3 - Setting the overcurrent flag asserts the active-low alert and enters the error state.
// R4 - The alert output is not derived from the error flag and may change on its own.
// R5 - Bit 7 of the port 1 status reads 1 once the programmed charge has been delivered.
// R6 - The ration done flag clears on read, on ration restart, or when rationing is disabled.
// R7 - Bit 4 of the port 1 status reads 1 while port 1 is in constant-current mode.
// R8 - Bit 3 of the port 1 status is the OR of the power enable pin and the override bit.
// R9 - A set condition present in the cycle of a clearing read wins, so the flag stays 1.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module ppsf_status_flags
    import ppsf_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        port2_over_limit,
    input  wire logic        port2_over_min,
    input  wire logic        port1_ration_reached,
    input  wire logic        port1_constant_current,
    input  wire logic        port1_power_enable_pin,
    output logic             port2_alert_n,
    output logic             port2_error_state,
    output logic             port1_ration_restart
);

    // ****************************************
    // Bus decode
    // ****************************************
    logic        access;
    logic        rd_access;
    logic        wr_access;
    logic        addr_hit;
    logic        setup;

    // Slave never stalls; answer comes in the first access cycle
    assign pready    = 1'b1;
    assign access    = psel & penable;
    assign setup     = psel & ~penable;
    assign rd_access = access & ~pwrite;
    assign wr_access = access & pwrite;
    assign addr_hit  = (paddr == PPSF_ADDR_P2_INT_STAT) |
                       (paddr == PPSF_ADDR_P1_GEN_STAT) |
                       (paddr == PPSF_ADDR_CONTROL) |
                       (paddr == PPSF_ADDR_ERROR);
    assign pslverr   = access & ~addr_hit;

    // ****************************************
    // State
    // ****************************************
    logic          pin_meta_q;
    logic          pin_sync_q;
    logic          pin_sync_d;
    logic          ovc_q;
    logic          ovc_d;
    logic          err_q;
    logic          err_d;
    logic          alert_n_q;
    logic          alert_n_d;
    logic          ration_q;
    logic          ration_d;
    logic          restart_q;
    logic          restart_d;
    ppsf_ctrl_type ctrl_q;
    ppsf_ctrl_type ctrl_d;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    logic          ovc_cond;
    logic          ovc_rd;
    logic          ration_rd;
    logic          err_clr;
    logic          ctrl_wr;

    assign ovc_cond  = port2_over_limit & port2_over_min;  // R1
    assign ovc_rd    = rd_access & (paddr == PPSF_ADDR_P2_INT_STAT);
    assign ration_rd = rd_access & (paddr == PPSF_ADDR_P1_GEN_STAT);
    assign ctrl_wr   = wr_access & (paddr == PPSF_ADDR_CONTROL);
    assign err_clr   = wr_access & (paddr == PPSF_ADDR_ERROR) &
                       pwdata[PPSF_BIT_ERR];

    // Next-state for flags, control and read data
    always_comb begin
        pin_sync_d = pin_meta_q;
        // Condition still present keeps the flag set over any clear
        ovc_d      = ovc_cond | (ovc_q & ~ovc_rd & ~err_clr);  // R1 R2 R9
        // Error state entered with the flag, left only by software
        err_d      = (ovc_cond & ~ovc_q) | (err_q & ~err_clr);  // R3
        // Alert follows the overcurrent flag, not the error flag
        alert_n_d  = ~ovc_d;  // R3 R4
        ration_d   = port1_ration_reached |
                     (ration_q & ~ration_rd & ~restart_q &
                      ctrl_q.ration_enable);  // R5 R6 R9
        ctrl_d     = ctrl_q;
        restart_d  = 1'b0;
        if (ctrl_wr) begin
            ctrl_d.ration_enable  = pwdata[PPSF_BIT_RATION_EN];
            ctrl_d.power_override = pwdata[PPSF_BIT_OVERRIDE];
            restart_d             = pwdata[PPSF_BIT_RESTART];
        end
        rdata_d = rdata_q;
        if (setup) begin
            rdata_d = PPSF_ZERO_WORD;
            unique case (paddr)
                PPSF_ADDR_P2_INT_STAT: begin
                    rdata_d[PPSF_BIT_OVC] = ovc_q;
                end
                PPSF_ADDR_P1_GEN_STAT: begin
                    rdata_d[PPSF_BIT_RATION] = ration_q;  // R5
                    rdata_d[PPSF_BIT_CC]     = port1_constant_current;  // R7
                    rdata_d[PPSF_BIT_PWR]    = pin_sync_q |
                                               ctrl_q.power_override;  // R8
                end
                PPSF_ADDR_CONTROL: begin
                    rdata_d[PPSF_BIT_RATION_EN] = ctrl_q.ration_enable;
                    rdata_d[PPSF_BIT_OVERRIDE]  = ctrl_q.power_override;
                end
                PPSF_ADDR_ERROR: begin
                    rdata_d[PPSF_BIT_ERR] = err_q;
                end
                default: begin
                    rdata_d = PPSF_ZERO_WORD;
                end
            endcase
        end
    end

    // Registers; pin passes two flops before any logic sees it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            ovc_q      <= 1'b0;
            err_q      <= 1'b0;
            alert_n_q  <= 1'b1;
            ration_q   <= 1'b0;
            restart_q  <= 1'b0;
            ctrl_q     <= PPSF_CTRL_RESET;
            rdata_q    <= PPSF_ZERO_WORD;
        end else begin
            pin_meta_q <= port1_power_enable_pin;
            pin_sync_q <= pin_sync_d;
            ovc_q      <= ovc_d;
            err_q      <= err_d;
            alert_n_q  <= alert_n_d;
            ration_q   <= ration_d;
            restart_q  <= restart_d;
            ctrl_q     <= ctrl_d;
            rdata_q    <= rdata_d;
        end
    end

    assign prdata               = rdata_q;
    assign port2_alert_n        = alert_n_q;
    assign port2_error_state    = err_q;
    assign port1_ration_restart = restart_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_read_ovc;
        ovc_rd & ~ovc_cond & ~err_clr;
    endsequence

    // Error held with the condition gone, then a quiet read of the flag
    sequence s_err_quiet;
        err_q & ~err_clr & ~ovc_cond;
    endsequence

    sequence s_read_quiet;
        ovc_rd & ~err_clr & ~ovc_cond;
    endsequence

    AST_OVC_SET: assert property ( // R1
        ovc_cond |=> ovc_q)
        else $error("overcurrent flag not set");
    AST_OVC_CLR_READ: assert property ( // R2
        s_read_ovc |=> !ovc_q)
        else $error("overcurrent flag not cleared by read");
    AST_OVC_CLR_ERR: assert property ( // R2
        err_clr & ~ovc_cond |=> !ovc_q && !err_q)
        else $error("error clear did not clear flag");
    AST_ALERT_ERR: assert property ( // R3
        ovc_cond & ~ovc_q |=> !port2_alert_n && port2_error_state)
        else $error("alert or error state missing");
    AST_ALERT_INDEP: assert property ( // R4
        s_err_quiet ##1 s_read_quiet
        |=> port2_alert_n && port2_error_state)
        else $error("alert tied to error flag");
    AST_RATION_SET: assert property ( // R5
        port1_ration_reached ##1 setup & (paddr == PPSF_ADDR_P1_GEN_STAT)
        |=> prdata[PPSF_BIT_RATION])
        else $error("ration done not reported");
    AST_RATION_CLR: assert property ( // R6
        (ration_rd | restart_q | ~ctrl_q.ration_enable) &
        ~port1_ration_reached |=> !ration_q)
        else $error("ration done not cleared");
    AST_CC_READ: assert property ( // R7
        setup & (paddr == PPSF_ADDR_P1_GEN_STAT)
        |=> prdata[PPSF_BIT_CC] == $past(port1_constant_current))
        else $error("cc mode bit wrong");
    AST_PWR_READ: assert property ( // R8
        setup & (paddr == PPSF_ADDR_P1_GEN_STAT)
        |=> prdata[PPSF_BIT_PWR] ==
            ($past(pin_sync_q) | $past(ctrl_q.power_override)))
        else $error("power enable state wrong");
    AST_OVC_SET_WINS: assert property ( // R9
        ovc_rd & ovc_cond |=> ovc_q)
        else $error("read beat a pending overcurrent set");
    AST_RATION_SET_WINS: assert property ( // R9
        ration_rd & port1_ration_reached |=> ration_q)
        else $error("read beat a pending ration set");
    AST_RESTART_PULSE: assert property ( // R6
        ctrl_wr & pwdata[PPSF_BIT_RESTART] |=> port1_ration_restart)
        else $error("ration restart pulse missing");

endmodule

// ===== sim/ppsf_host.sv
// Management host model: APB master for the status flag bank.
// Assumes one clock; waits on pready, bounded by the bench watchdog.
`timescale 1ns/1ns
module ppsf_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer; request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ===== sim/ppsf_status_flags_tb.sv
// Self-checking bench for the status flag bank.
// Assumes the host model drives APB; flag inputs driven here.
`timescale 1ns/1ns
module ppsf_status_flags_tb;
    import ppsf_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        lim, mn, rch, cc, pin, al_n, err, rst;
    int          num_errors, comparisons;

    // ****************************************
    // Clock, reset, instances
    // ****************************************
    always #20 pclk = ~pclk;
    ppsf_host host (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    ppsf_status_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port2_over_limit(lim), .port2_over_min(mn),
        .port1_ration_reached(rch), .port1_constant_current(cc),
        .port1_power_enable_pin(pin), .port2_alert_n(al_n),
        .port2_error_state(err), .port1_ration_restart(rst));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic x;
        host.xfer(1'b0, a, PPSF_ZERO_WORD, r, x);
        chk(e, r);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic x;
        host.xfer(1'b1, a, d, r, x);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // One reached pulse, one cycle wide; returns at the edge that drops it
    task automatic pulse;
        @(posedge pclk);
        rch <= 1'b1;
        @(posedge pclk);
        rch <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_ovc;
        @(posedge pclk);
        lim <= 1'b1;
        wt(2);
        rd(8'h04, 32'h0);
        mn <= 1'b1;
        wt(2);
        chk(32'h0, al_n);
        chk(32'h1, err);
        rd(8'h04, 32'h1);
        rd(8'h04, 32'h1);
        lim <= 1'b0;
        rd(8'h04, 32'h1);
        rd(8'h04, 32'h0);
        wt(2);
        chk(32'h1, al_n);
        chk(32'h1, err);
        rd(8'h14, 32'h1);
        lim <= 1'b1;
        wt(2);
        @(posedge pclk);
        lim <= 1'b0;
        wr(8'h14, 32'h1);
        rd(8'h04, 32'h0);
        wt(2);
        chk(32'h0, err);
        chk(32'h1, al_n);
    endtask
    task automatic t_rat;
        wr(8'h10, 32'h2);
        @(posedge pclk);
        rch <= 1'b1;
        @(posedge pclk);
        rd(8'h08, 32'h80);
        rd(8'h08, 32'h80);
        rch <= 1'b0;
        rd(8'h08, 32'h80);
        rd(8'h08, 32'h0);
        pulse;
        wr(8'h10, 32'h3);
        #1 chk(32'h1, rst);
        wt(1);
        chk(32'h0, rst);
        rd(8'h08, 32'h0);
        pulse;
        wr(8'h10, 32'h0);
        wt(1);
        rd(8'h08, 32'h0);
    endtask
    task automatic t_gen;
        logic x;
        cc <= 1'b1;
        pin <= 1'b1;
        wt(4);
        rd(8'h08, 32'h18);
        cc <= 1'b0;
        pin <= 1'b0;
        wr(8'h10, 32'h4);
        wt(4);
        rd(8'h08, 32'h08);
        rd(8'h10, 32'h4);
        wr(8'h10, 32'h0);
        wt(4);
        rd(8'h08, 32'h0);
        host.xfer(1'b0, 8'h3C, PPSF_ZERO_WORD, r, x);
        chk(32'h1, x);
        chk(32'h0, r);
        chk(32'h1, pready);
    endtask

    // Verdict and end of run
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence; reset held for two cycles
    initial begin
        {pclk, presetn, lim, mn, rch, cc, pin} = 7'h00;
        num_errors = 0;
        comparisons = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_ovc;
        t_rat;
        t_gen;
        wrap_up;
    end
    // Watchdog, well beyond the hundred or so cycles the tests need
    initial begin
        #200000;
        num_errors++;
        wrap_up;
    end
endmodule
